// File: gpio_table_mapper_map.svh
`ifndef GPIO_TABLE_MAPPER_MAP_SVH
`define GPIO_TABLE_MAPPER_MAP_SVH

// Register addresses of the per-pin mapping registers
`define MAP_PIN0_ADDR    8'hE0
`define MAP_PIN1_ADDR    8'hE1
`define MAP_PIN2_ADDR    8'hE2
`define MAP_PIN3_ADDR    8'hE3

// Reset values of the mapping registers
`define MAP_PIN0_RST     8'h00
`define MAP_PIN1_RST     8'h00
`define MAP_PIN2_RST     8'h60
`define MAP_PIN3_RST     8'h00

// Field layout of a mapping register
`define MAP_ROLE_BIT     7
`define MAP_INDEX_MSB    6
`define MAP_INDEX_LSB    0

// Role encodings of the role select bit
`define ROLE_CONTROL     1'h0
`define ROLE_STATUS      1'h1

// Table index that marks a control pin as unused
`define UNUSED_INDEX     7'h00

// Control table bit that enables fast differential output 0
`define FAST_DIFF0_INDEX 7'h60

// Answer to a read of an unmapped address
`define UNMAPPED_DATA    8'h00

`endif

// File: gpio_table_mapper_pkg.sv
package gpio_table_mapper_pkg;

  // Index of one bit within the control or status table
  typedef logic [6:0] bit_index_t;

  // One mapping register: role select above the table index
  typedef struct packed {
    logic       role_select;
    bit_index_t bit_index;
  } pin_map_s;

  // Register access request from the configuration port
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } reg_req_s;

  // Register read answer
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } reg_rsp_s;

endpackage

// File: gpio_table_mapper.sv
`timescale 1ns/1ps
`include "gpio_table_mapper_map.svh"

module gpio_table_mapper #(
  parameter int NUM_PINS   = 4,
  parameter int TABLE_BITS = 128
) (
  input  wire logic                              ref_clk_in,
  input  wire logic                              sys_rst_in,
  input  wire gpio_table_mapper_pkg::reg_req_s   reg_req_in,
  output gpio_table_mapper_pkg::reg_rsp_s        reg_rsp_out,
  input  wire logic [NUM_PINS-1:0]               pin_in,
  output logic      [NUM_PINS-1:0]               pin_out,
  output logic      [NUM_PINS-1:0]               pin_oe_out,
  input  wire logic [TABLE_BITS-1:0]             status_table_in,
  output logic      [TABLE_BITS-1:0]             ctrl_table_out,
  output logic                                   fast_diff_output0_enable_out
);

  // Only four reset values exist, and a 7-bit index must span the table exactly
  if (NUM_PINS < 1 || NUM_PINS > 4)
  begin : g_pins_check
    $error("NUM_PINS must be 1 to 4");
  end
  if (TABLE_BITS != (1 << ($bits(gpio_table_mapper_pkg::bit_index_t))))
  begin : g_table_check
    $error("TABLE_BITS must equal two to the index width");
  end

  // All state of the block
  typedef struct packed {
    gpio_table_mapper_pkg::pin_map_s [NUM_PINS-1:0] map;
    logic [TABLE_BITS-1:0]                          ctrl;
    logic [NUM_PINS-1:0]                            sync1;
    logic [NUM_PINS-1:0]                            sync2;
    logic [NUM_PINS-1:0]                            drive;
    logic [NUM_PINS-1:0]                            oe;
    gpio_table_mapper_pkg::reg_rsp_s                rsp;
  } state_s;

  state_s q;
  state_s d;

  // True when the address falls on one of the mapping registers
  function automatic logic is_map_addr(input logic [7:0] a);
    return (a >= `MAP_PIN0_ADDR) && ({24'h000000, a} < ({24'h000000, `MAP_PIN0_ADDR} + NUM_PINS));
  endfunction

  // Pin number served by a mapping register address
  function automatic int pin_of(input logic [7:0] a);
    logic [7:0] ofs;
    ofs = a - `MAP_PIN0_ADDR;
    return int'(ofs);
  endfunction

  // Reset state; the map values are the documented defaults
  function automatic state_s reset_state();
    state_s s;
    s = '0;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      case (i)
        0:       s.map[i] = `MAP_PIN0_RST;
        1:       s.map[i] = `MAP_PIN1_RST;
        2:       s.map[i] = `MAP_PIN2_RST;
        default: s.map[i] = `MAP_PIN3_RST;
      endcase
    end
    return s;
  endfunction

  // Next state: register port, pin synchroniser, table mapping
  always_comb
  begin
    d           = q;
    d.sync1     = pin_in;
    d.sync2     = q.sync1;
    d.rsp.valid = 1'b0;

    // Register writes take effect on the next edge
    if (reg_req_in.wr && is_map_addr(reg_req_in.addr))
    begin
      d.map[pin_of(reg_req_in.addr)] = reg_req_in.wdata;
    end

    // Reads return the value held before any write in the same cycle
    if (reg_req_in.rd)
    begin
      d.rsp.valid = 1'b1;
      if (is_map_addr(reg_req_in.addr))
      begin
        d.rsp.data = q.map[pin_of(reg_req_in.addr)];
      end
      else
      begin
        d.rsp.data = `UNMAPPED_DATA;
      end
    end

    // Higher pins are applied last, so they win when two pins share a control bit
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (q.map[i].role_select == `ROLE_STATUS)
      begin
        d.oe[i]    = 1'b1;
        d.drive[i] = status_table_in[q.map[i].bit_index];
      end
      else
      begin
        d.oe[i]    = 1'b0;
        d.drive[i] = 1'b0;
        // Index zero is the unused marker, so control bit zero is never written
        if (q.map[i].bit_index != `UNUSED_INDEX)
        begin
          d.ctrl[q.map[i].bit_index] = q.sync2[i];
        end
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      q <= reset_state();
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign reg_rsp_out                  = q.rsp;
  assign pin_out                      = q.drive;
  assign pin_oe_out                   = q.oe;
  assign ctrl_table_out               = q.ctrl;
  assign fast_diff_output0_enable_out = q.ctrl[`FAST_DIFF0_INDEX];

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // Pin 0 and pin 2 defaults are present on the first edge after reset
  reset_map_a: assert property (
    $past(sys_rst_in) |->
      (q.map[0] == `MAP_PIN0_RST) && ((NUM_PINS < 3) || (q.map[2] == `MAP_PIN2_RST)))
    else $error("map registers not at reset value");

  // Unused marker keeps control bit zero clear
  unused_bit_a: assert property (
    q.ctrl[0] == 1'b0)
    else $error("control bit zero written");

  // Writes to the pin 0 register land one edge later
  map_write_a: assert property (
    reg_req_in.wr && (reg_req_in.addr == `MAP_PIN0_ADDR) |=> q.map[0] == $past(reg_req_in.wdata))
    else $error("map write lost");

  // Unmapped read answers one cycle later with zero
  read_back_a: assert property (
    reg_req_in.rd && !is_map_addr(reg_req_in.addr) |=>
      reg_rsp_out.valid && (reg_rsp_out.data == `UNMAPPED_DATA))
    else $error("unmapped read answer wrong");

  for (genvar g = 0; g < NUM_PINS; g++)
  begin : g_pin_checks
    // Output enable follows the role bit one edge later
    pin_role_a: assert property (
      !$past(sys_rst_in) |-> pin_oe_out[g] == $past(q.map[g].role_select))
      else $error("pin enable does not follow role");

    // Status pins present the addressed status bit
    status_drive_a: assert property (
      !$past(sys_rst_in) && $past(q.map[g].role_select) |->
        pin_out[g] == $past(status_table_in[q.map[g].bit_index]))
      else $error("status pin value wrong");

    // Top pin's control level reaches its table bit three edges after the pin
    if (g == NUM_PINS - 1)
    begin : g_top
      ctrl_copy_a: assert property (
        !$past(sys_rst_in) && !$past(q.map[g].role_select) &&
        ($past(q.map[g].bit_index) != `UNUSED_INDEX) |->
          ctrl_table_out[$past(q.map[g].bit_index)] == $past(pin_in[g], 3))
        else $error("control bit not copied from pin");
    end
  end

endmodule // gpio_table_mapper

// File: board_pins.sv
`timescale 1ns/1ps
// Board side of the four pins: a pin the device drives shows the device level,
// any other pin shows what the board drives, so a role slip shows up at once
module board_pins (
  input  wire logic [3:0] pin_out_in,
  input  wire logic [3:0] pin_oe_in,
  input  wire logic [3:0] drive_in,
  output logic      [3:0] pin_level_out
);
  // Resolve each wire from both parties' drive
  assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & drive_in);
endmodule // board_pins

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic                            ref_clk_in;
  logic                            sys_rst_in;
  gpio_table_mapper_pkg::reg_req_s req;
  gpio_table_mapper_pkg::reg_rsp_s rsp;
  logic [3:0]                      drive;
  logic [3:0]                      level;
  logic [3:0]                      pin_out;
  logic [3:0]                      pin_oe;
  logic [127:0]                    status_tbl;
  logic [127:0]                    ctrl_tbl;
  logic                            fast0;
  int                              n_errors;
  int                              n_compared;

  gpio_table_mapper dut_u (
    .ref_clk_in                   (ref_clk_in),
    .sys_rst_in                   (sys_rst_in),
    .reg_req_in                   (req),
    .reg_rsp_out                  (rsp),
    .pin_in                       (level),
    .pin_out                      (pin_out),
    .pin_oe_out                   (pin_oe),
    .status_table_in              (status_tbl),
    .ctrl_table_out               (ctrl_tbl),
    .fast_diff_output0_enable_out (fast0)
  );

  board_pins board_u (
    .pin_out_in    (pin_out),
    .pin_oe_in     (pin_oe),
    .drive_in      (drive),
    .pin_level_out (level)
  );

  // 25 MHz clock
  initial
  begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  // Inputs always move 1 ns after the edge, away from sampling
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Strobe for one edge; the register takes the byte at that edge.
  // An idle edge follows so the next call never re-drives req in the same step.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    step(1);
    req.wr = 1'b0;
    step(1);
  endtask

  // Read answer arrives as a one-cycle valid; a bounded wait guards a hang
  task automatic read_reg(input logic [7:0] a, input logic [7:0] exp);
    int i;
    req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    step(1);
    req.rd = 1'b0;
    i = 0;
    while (rsp.valid !== 1'b1 && i < 4)
    begin
      step(1);
      i++;
    end
    if (i == 4)
    begin
      n_errors++;
      complete_run();
    end
    else
    begin
      check(rsp.data, exp);
      step(1);
    end
  endtask

  // Main sequence
  initial
  begin
    n_errors = 0;
    n_compared = 0;
    sys_rst_in = 1'b1;
    req = '0;
    drive = 4'h0;
    status_tbl = '0;
    step(8);
    sys_rst_in = 1'b0;
    // Defaults, with a stray write to an unmapped address first
    write_reg(8'hE4, 8'hFF);
    read_reg(8'hE4, 8'h00);
    read_reg(8'hE0, 8'h00);
    read_reg(8'hE1, 8'h00);
    read_reg(8'hE2, 8'h60);
    read_reg(8'hE3, 8'h00);
    $display("Test reset values done");
    // Pin 2 out of reset steers the fast output enable; unused pins change nothing
    drive = 4'hF;
    step(3);
    check(fast0, 8'h01);
    check(ctrl_tbl[96], 8'h01);
    check(ctrl_tbl[0], 8'h00);
    drive = 4'h0;
    step(3);
    check(fast0, 8'h00);
    $display("Test default pin 2 done");
    // Status role at index 5 and at the top of the index range
    write_reg(8'hE0, 8'h85);
    write_reg(8'hE1, 8'hFF);
    read_reg(8'hE0, 8'h85);
    read_reg(8'hE1, 8'hFF);
    status_tbl[5] = 1'b1;
    step(2);
    check(pin_oe[1:0], 8'h03);
    check(pin_out[1:0], 8'h01);
    status_tbl[5] = 1'b0;
    status_tbl[127] = 1'b1;
    step(2);
    check(pin_out[1:0], 8'h02);
    $display("Test status pins done");
    // Control role: pin 2 moved to bit 42, pin 3 to the top bit
    write_reg(8'hE2, 8'h2A);
    write_reg(8'hE3, 8'h7F);
    drive = 4'hC;
    step(4);
    check(ctrl_tbl[42], 8'h01);
    check(ctrl_tbl[127], 8'h01);
    check(pin_oe[3:2], 8'h00);
    check(fast0, 8'h00);
    $display("Test control pins done");
    complete_run();
  end
endmodule // tb_top
